// File: verif/sef_error_flags_tb_top.sv
// self-checking bench of the receiver error flag block
`timescale 1ns/10ps
`include "sef_regs.svh"
`define CHK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, act, exp); end end
module sef_error_flags_tb_top;
  logic       clk = 1'b0, arst_n = 1'b0, rd = 1'b0, wr = 1'b0, cap_req = 1'b0, ce = 1'b1;
  logic [6:0] addr = 7'h00;
  logic [7:0] wdata = 8'h00, rdata;
  logic       rvalid, cap, summary, sub = 1'b0, vld = 1'b0, emph = 1'b0, na_cs = 1'b0;
  logic       na_pre = 1'b0, crc = 1'b0, absent = 1'b0, biph = 1'b0, lock = 1'b0;
  logic [4:0] na_type = 5'h00;
  logic [15:0] wa = 16'h0000, wb = 16'h0000, wc = 16'h0000, fa, fb, fc;
  int         error_cnt = 0, samples_checked = 0;

  initial forever #2.5 clk = ~clk;

  sef_front_model front_u (.ref_clk_i(clk), .arst_n_i(arst_n), .cap_req_i(cap_req),
    .word_a_i(wa), .word_b_i(wb), .word_c_i(wc), .burst_capture_o(cap),
    .first_burst_word_o(fa), .second_burst_word_o(fb), .chan_b_burst_word_o(fc));

  sef_error_flags #(.TYPE_W(5)) dut_u (.ref_clk_i(clk), .arst_n_i(arst_n), .ce_i(ce),
    .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .burst_capture_i(cap),
    .first_burst_word_i(fa), .second_burst_word_i(fb), .chan_b_burst_word_i(fc),
    .subframe_nonaudio_i(sub), .rx_validity_flag_i(vld), .emphasis_i(emph),
    .nonaudio_cs_i(na_cs), .nonaudio_type_i(na_type), .nonaudio_preamble_i(na_pre),
    .chan_status_check_fail_i(crc), .input_absent_flag_i(absent),
    .biphase_parity_err_i(biph), .pll_lock_i(lock), .receiver_fault_summary_o(summary));

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clk) begin rd <= 1'b1; addr <= a; end
    @(posedge clk) rd <= 1'b0;
    #1 `CHK({rvalid, rdata}, {1'b1, exp})
  endtask

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge clk) wr <= 1'b0;
  endtask

  task automatic capture(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge clk) begin cap_req <= 1'b1; wa <= a; wb <= b; wc <= c; end
    @(posedge clk) cap_req <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic irq_chk(input logic exp);
    repeat (4) @(posedge clk);
    #1 `CHK(summary, exp)
  endtask

  task automatic t_reset_map;
    rd_chk(`SEF_OFF_ERR, 8'h00);
    rd_chk(`SEF_OFF_MASK, 8'h00);
    rd_chk(7'h1a, 8'h00);
    wr_reg(`SEF_OFF_MASK, 8'ha5);
    rd_chk(`SEF_OFF_MASK, 8'ha5);
    wr_reg(`SEF_OFF_ERR, 8'hff);
    rd_chk(`SEF_OFF_ERR, 8'h00);
    wr_reg(`SEF_OFF_MASK, 8'h00);
  endtask

  task automatic t_preamble;
    capture(16'h1234, 16'h5678, 16'h9abc);
    rd_chk(`SEF_OFF_PRE_A_LO, 8'h00);
    rd_chk(`SEF_OFF_PRE_B_HI, 8'h00);
    @(posedge clk) na_pre <= 1'b1;
    capture(16'h1234, 16'h5678, 16'h9abc);
    rd_chk(`SEF_OFF_PRE_A_HI, 8'h12);
    rd_chk(`SEF_OFF_PRE_A_LO, 8'h34);
    rd_chk(`SEF_OFF_PRE_B_HI, 8'h56);
    rd_chk(`SEF_OFF_PRE_B_LO, 8'h78);
    @(posedge clk) sub <= 1'b1;
    capture(16'hc3e1, 16'h0f0f, 16'h9abc);
    rd_chk(`SEF_OFF_PRE_B_HI, 8'h9a);
    rd_chk(`SEF_OFF_PRE_B_LO, 8'hbc);
  endtask

  task automatic t_flags;
    @(posedge clk) begin vld <= 1'b1; emph <= 1'b1; na_cs <= 1'b1; absent <= 1'b1; end
    @(posedge clk) begin lock <= 1'b1; crc <= 1'b1; biph <= 1'b1; end
    @(posedge clk) begin crc <= 1'b0; biph <= 1'b0; end
    repeat (2) @(posedge clk);
    rd_chk(`SEF_OFF_ERR, 8'hff);
    rd_chk(`SEF_OFF_ERR, 8'hf5);
    @(posedge clk) lock <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(`SEF_OFF_ERR, 8'hf4);
  endtask

  task automatic t_irq;
    wr_reg(`SEF_OFF_MASK, 8'h01);
    irq_chk(1'b0);
    @(posedge clk) lock <= 1'b1;
    irq_chk(1'b1);
    rd_chk(`SEF_OFF_ERR, 8'hf5);
    irq_chk(1'b0);
    wr_reg(`SEF_OFF_MASK, 8'h40);
    irq_chk(1'b0);
    @(posedge clk) emph <= 1'b0;
    irq_chk(1'b1);
    rd_chk(`SEF_OFF_ERR, 8'hb5);
    wr_reg(`SEF_OFF_MASK, 8'h20);
    irq_chk(1'b0);
    @(posedge clk) na_type <= 5'h0b;
    irq_chk(1'b1);
    rd_chk(`SEF_OFF_ERR, 8'hb5);
    wr_reg(`SEF_OFF_MASK, 8'hf5);
    @(posedge clk) biph <= 1'b1;
    @(posedge clk) biph <= 1'b0;
    irq_chk(1'b0);
    wr_reg(`SEF_OFF_MASK, 8'h02);
    irq_chk(1'b1);
    rd_chk(`SEF_OFF_ERR, 8'hb7);
    irq_chk(1'b0);
  endtask

  task automatic t_state_irq;
    wr_reg(`SEF_OFF_MASK, 8'h14);
    irq_chk(1'b0);
    @(posedge clk) na_pre <= 1'b0;
    irq_chk(1'b1);
    rd_chk(`SEF_OFF_PRE_A_HI, 8'h00);
    rd_chk(`SEF_OFF_ERR, 8'ha5);
    irq_chk(1'b0);
    @(posedge clk) absent <= 1'b0;
    irq_chk(1'b1);
    rd_chk(`SEF_OFF_ERR, 8'ha1);
    irq_chk(1'b0);
  endtask

  // with the enable low nothing moves, not even a mask write
  task automatic t_freeze;
    wr_reg(`SEF_OFF_MASK, 8'h01);
    @(posedge clk) begin ce <= 1'b0; lock <= 1'b0; end
    irq_chk(1'b0);
    wr_reg(`SEF_OFF_MASK, 8'h00);
    @(posedge clk) ce <= 1'b1;
    irq_chk(1'b1);
    rd_chk(`SEF_OFF_MASK, 8'h01);
    rd_chk(`SEF_OFF_ERR, 8'ha0);
  endtask

  task automatic t_mid_reset;
    @(posedge clk) arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk(`SEF_OFF_MASK, 8'h00);
    rd_chk(`SEF_OFF_ERR, 8'ha0);
    irq_chk(1'b0);
  endtask

  task automatic give_verdict;
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #20000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset_map();
    t_preamble();
    t_flags();
    t_irq();
    t_state_irq();
    t_freeze();
    t_mid_reset();
    give_verdict();
  end
endmodule

// File: verif/sef_front_model.sv
// receiver front-end model that hands burst preamble words to the block
`timescale 1ns/10ps
module sef_front_model (
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        cap_req_i,
  input  wire logic [15:0] word_a_i,
  input  wire logic [15:0] word_b_i,
  input  wire logic [15:0] word_c_i,
  output logic             burst_capture_o,
  output logic      [15:0] first_burst_word_o,
  output logic      [15:0] second_burst_word_o,
  output logic      [15:0] chan_b_burst_word_o
);
  // words are only good with the strobe; otherwise they show the inverse
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      burst_capture_o     <= 1'b0;
      first_burst_word_o  <= 16'hffff;
      second_burst_word_o <= 16'hffff;
      chan_b_burst_word_o <= 16'hffff;
    end else begin
      burst_capture_o     <= cap_req_i;
      first_burst_word_o  <= cap_req_i ? word_a_i : ~word_a_i;
      second_burst_word_o <= cap_req_i ? word_b_i : ~word_b_i;
      chan_b_burst_word_o <= cap_req_i ? word_c_i : ~word_c_i;
    end
  end
endmodule

// File: verilog/sef_error_flags.sv
// receiver error flags, burst preamble capture and interrupt request
//
// Overview of operation
// - first preamble low byte reads at 0x15
// - preamble registers read zero unless nonaudio detected
// - second preamble high byte reads at 0x16
// - second preamble low byte reads at 0x17
// - subframe mode: second registers hold channel B
// - error bit 7 follows received validity bit
// - bit 6 emphasis, interrupts again only on change
// - bit 5 nonaudio, reinterrupts on change or type
// - bit 4 preamble nonaudio, interrupts on change only
// - bit 3 check failure latched until read
// - bit 2 no stream, interrupts on change only
// - bit 1 biphase/parity error latched until read
// - bit 0 follows lock, interrupts on change
// - mask bit one enables matching error interrupt
// - first preamble high byte reads at 0x14
// - enabled event raises summary flag, host reads promptly
`timescale 1ns/10ps
`include "sef_regs.svh"
module sef_error_flags #(
  parameter int TYPE_W = 5
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    arst_n_i,
  input  wire logic                    ce_i,
  input  wire logic [`SEF_ADDR_W-1:0]  reg_addr_i,
  input  wire logic                    reg_rd_i,
  input  wire logic                    reg_wr_i,
  input  wire logic [7:0]              reg_wdata_i,
  output logic      [7:0]              reg_rdata_o,
  output logic                         reg_rvalid_o,
  input  wire logic                    burst_capture_i,
  input  wire logic [15:0]             first_burst_word_i,
  input  wire logic [15:0]             second_burst_word_i,
  input  wire logic [15:0]             chan_b_burst_word_i,
  input  wire logic                    subframe_nonaudio_i,
  input  wire logic                    rx_validity_flag_i,
  input  wire logic                    emphasis_i,
  input  wire logic                    nonaudio_cs_i,
  input  wire logic [TYPE_W-1:0]       nonaudio_type_i,
  input  wire logic                    nonaudio_preamble_i,
  input  wire logic                    chan_status_check_fail_i,
  input  wire logic                    input_absent_flag_i,
  input  wire logic                    biphase_parity_err_i,
  input  wire logic                    pll_lock_i,
  output logic                         receiver_fault_summary_o
);

  sef_pkg::sef_word_t pre_a;
  sef_pkg::sef_word_t pre_b;
  sef_pkg::sef_byte_t flags;
  sef_pkg::sef_byte_t irq_enable;
  sef_pkg::sef_byte_t events;
  sef_pkg::sef_byte_t pending;
  sef_pkg::sef_byte_t next_flags;
  sef_pkg::sef_byte_t next_rdata;
  sef_pkg::sef_sel_t  sel;
  logic [TYPE_W-1:0]  na_type;
  logic               err_read;
  logic               detected;

  // byte of a captured word, forced to zero while no burst is recognised
  function automatic sef_pkg::sef_byte_t gated_byte(input sef_pkg::sef_word_t word,
                                                    input logic hi, input logic det);
    sef_pkg::sef_byte_t b;
    b = hi ? word[15:8] : word[7:0];
    return det ? b : `SEF_BYTE_ZERO;
  endfunction

  always_comb begin
    if (reg_addr_i == `SEF_OFF_PRE_A_HI) begin
      sel = sef_pkg::SEF_SEL_PRE_A_HI;
    end else if (reg_addr_i == `SEF_OFF_PRE_A_LO) begin
      sel = sef_pkg::SEF_SEL_PRE_A_LO;
    end else if (reg_addr_i == `SEF_OFF_PRE_B_HI) begin
      sel = sef_pkg::SEF_SEL_PRE_B_HI;
    end else if (reg_addr_i == `SEF_OFF_PRE_B_LO) begin
      sel = sef_pkg::SEF_SEL_PRE_B_LO;
    end else if (reg_addr_i == `SEF_OFF_ERR) begin
      sel = sef_pkg::SEF_SEL_ERR;
    end else if (reg_addr_i == `SEF_OFF_MASK) begin
      sel = sef_pkg::SEF_SEL_MASK;
    end else begin
      sel = sef_pkg::SEF_SEL_NONE;
    end
  end

  assign err_read = ce_i && reg_rd_i && (sel == sef_pkg::SEF_SEL_ERR);
  assign detected = flags[`SEF_BIT_NA_PRE];

  // burst preamble capture
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pre_a <= `SEF_WORD_ZERO;
      pre_b <= `SEF_WORD_ZERO;
    end else if (ce_i && burst_capture_i) begin
      pre_a <= first_burst_word_i;
      if (subframe_nonaudio_i) begin
        pre_b <= chan_b_burst_word_i;
      end else begin
        pre_b <= second_burst_word_i;
      end
    end
  end

  always_comb begin
    next_flags                    = flags;
    next_flags[`SEF_BIT_VALID]    = rx_validity_flag_i;
    next_flags[`SEF_BIT_EMPH]     = emphasis_i;
    next_flags[`SEF_BIT_NONAUDIO] = nonaudio_cs_i;
    next_flags[`SEF_BIT_NA_PRE]   = nonaudio_preamble_i;
    next_flags[`SEF_BIT_ABSENT]   = input_absent_flag_i;
    next_flags[`SEF_BIT_LOCK]     = pll_lock_i;
    // latched errors survive a read that meets a new error
    next_flags[`SEF_BIT_CRC]      = chan_status_check_fail_i
                                    | (flags[`SEF_BIT_CRC] & ~err_read);
    next_flags[`SEF_BIT_BIPHASE]  = biphase_parity_err_i
                                    | (flags[`SEF_BIT_BIPHASE] & ~err_read);
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags   <= `SEF_BYTE_ZERO;
      na_type <= '0;
    end else if (ce_i) begin
      flags   <= next_flags;
      na_type <= nonaudio_type_i;
    end
  end

  // state flags raise an event when their state moves; nonaudio also on a type change while set
  always_comb begin
    events                    = `SEF_BYTE_ZERO;
    events[`SEF_BIT_VALID]    = rx_validity_flag_i != flags[`SEF_BIT_VALID];
    events[`SEF_BIT_EMPH]     = emphasis_i != flags[`SEF_BIT_EMPH];
    events[`SEF_BIT_NONAUDIO] = (nonaudio_cs_i != flags[`SEF_BIT_NONAUDIO])
                                | (nonaudio_cs_i & flags[`SEF_BIT_NONAUDIO]
                                   & (nonaudio_type_i != na_type));
    events[`SEF_BIT_NA_PRE]   = nonaudio_preamble_i != flags[`SEF_BIT_NA_PRE];
    events[`SEF_BIT_CRC]      = chan_status_check_fail_i;
    events[`SEF_BIT_ABSENT]   = input_absent_flag_i != flags[`SEF_BIT_ABSENT];
    events[`SEF_BIT_BIPHASE]  = biphase_parity_err_i;
    events[`SEF_BIT_LOCK]     = pll_lock_i != flags[`SEF_BIT_LOCK];
  end

  sef_event_tracker #(
    .WIDTH (8)
  ) u_tracker (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .ce_i      (ce_i),
    .event_i   (events),
    .clear_i   (err_read),
    .pending_o (pending)
  );

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_enable <= `SEF_MASK_RST;
    end else if (ce_i && reg_wr_i && (sel == sef_pkg::SEF_SEL_MASK)) begin
      irq_enable <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      receiver_fault_summary_o <= 1'b0;
    end else if (ce_i) begin
      receiver_fault_summary_o <= |(pending & irq_enable);
    end
  end

  always_comb begin
    case (sel)
      sef_pkg::SEF_SEL_PRE_A_HI: next_rdata = gated_byte(pre_a, 1'b1, detected);
      sef_pkg::SEF_SEL_PRE_A_LO: next_rdata = gated_byte(pre_a, 1'b0, detected);
      sef_pkg::SEF_SEL_PRE_B_HI: next_rdata = gated_byte(pre_b, 1'b1, detected);
      sef_pkg::SEF_SEL_PRE_B_LO: next_rdata = gated_byte(pre_b, 1'b0, detected);
      sef_pkg::SEF_SEL_ERR:      next_rdata = flags;
      sef_pkg::SEF_SEL_MASK:     next_rdata = irq_enable;
      default:                   next_rdata = `SEF_BYTE_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o  <= `SEF_BYTE_ZERO;
      reg_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_pre_a_lo;
    (ce_i && reg_rd_i && reg_addr_i == `SEF_OFF_PRE_A_LO && detected)
      |=> reg_rdata_o == $past(pre_a[7:0]);
  endproperty
  a_pre_a_lo: assert property (p_pre_a_lo)
    else $error("preamble a low byte read wrong");

  property p_pre_zero;
    (ce_i && reg_rd_i && !detected && reg_addr_i >= `SEF_OFF_PRE_A_HI
     && reg_addr_i <= `SEF_OFF_PRE_B_LO) |=> reg_rdata_o == `SEF_BYTE_ZERO;
  endproperty
  a_pre_zero: assert property (p_pre_zero)
    else $error("preamble byte not zero without burst");

  property p_pre_b_hi;
    (ce_i && reg_rd_i && reg_addr_i == `SEF_OFF_PRE_B_HI && detected)
      |=> reg_rdata_o == $past(pre_b[15:8]);
  endproperty
  a_pre_b_hi: assert property (p_pre_b_hi)
    else $error("preamble b high byte read wrong");

  property p_pre_b_lo;
    (ce_i && reg_rd_i && reg_addr_i == `SEF_OFF_PRE_B_LO && detected)
      |=> reg_rdata_o == $past(pre_b[7:0]);
  endproperty
  a_pre_b_lo: assert property (p_pre_b_lo)
    else $error("preamble b low byte read wrong");

  property p_chan_b;
    (ce_i && burst_capture_i && subframe_nonaudio_i) |=> pre_b == $past(chan_b_burst_word_i);
  endproperty
  a_chan_b: assert property (p_chan_b)
    else $error("channel b word not captured");

  property p_valid;
    (ce_i && reg_rd_i && reg_addr_i == `SEF_OFF_ERR)
      |=> reg_rdata_o[`SEF_BIT_VALID] == $past(flags[`SEF_BIT_VALID]);
  endproperty
  a_valid: assert property (p_valid)
    else $error("validity bit not reported");

  property p_emph_quiet;
    (err_read && emphasis_i == flags[`SEF_BIT_EMPH])
      |=> !pending[`SEF_BIT_EMPH] && flags[`SEF_BIT_EMPH] == $past(emphasis_i);
  endproperty
  a_emph_quiet: assert property (p_emph_quiet)
    else $error("emphasis event after read without change");

  property p_na_type;
    (ce_i && nonaudio_cs_i && flags[`SEF_BIT_NONAUDIO] && nonaudio_type_i != na_type)
      |=> pending[`SEF_BIT_NONAUDIO];
  endproperty
  a_na_type: assert property (p_na_type)
    else $error("nonaudio type change missed");

  property p_na_pre_quiet;
    (err_read && nonaudio_preamble_i == flags[`SEF_BIT_NA_PRE])
      |=> !pending[`SEF_BIT_NA_PRE];
  endproperty
  a_na_pre_quiet: assert property (p_na_pre_quiet)
    else $error("preamble nonaudio event after read without change");

  property p_absent_event;
    (ce_i && input_absent_flag_i != flags[`SEF_BIT_ABSENT])
      |=> pending[`SEF_BIT_ABSENT] && flags[`SEF_BIT_ABSENT] == $past(input_absent_flag_i);
  endproperty
  a_absent_event: assert property (p_absent_event)
    else $error("stream presence change not pending");

  property p_crc_hold;
    (ce_i && chan_status_check_fail_i) |=> flags[`SEF_BIT_CRC];
  endproperty
  a_crc_hold: assert property (p_crc_hold)
    else $error("check failure not latched");

  property p_crc_keep;
    (ce_i && flags[`SEF_BIT_CRC] && !err_read) |=> flags[`SEF_BIT_CRC];
  endproperty
  a_crc_keep: assert property (p_crc_keep)
    else $error("check failure cleared without read");

  property p_biphase_keep;
    (ce_i && flags[`SEF_BIT_BIPHASE] && !err_read) |=> flags[`SEF_BIT_BIPHASE];
  endproperty
  a_biphase_keep: assert property (p_biphase_keep)
    else $error("biphase error cleared without read");

  property p_lock_event;
    (ce_i && !err_read && pll_lock_i != flags[`SEF_BIT_LOCK])
      |=> pending[`SEF_BIT_LOCK] && flags[`SEF_BIT_LOCK] == $past(pll_lock_i);
  endproperty
  a_lock_event: assert property (p_lock_event)
    else $error("lock change not pending");

  property p_irq_masked;
    $rose(receiver_fault_summary_o) |-> $past(|(pending & irq_enable));
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("request raised without enabled pending event");

  property p_mask_write;
    (ce_i && reg_wr_i && reg_addr_i == `SEF_OFF_MASK) |=> irq_enable == $past(reg_wdata_i);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write not stored");

  property p_irq_follow;
    (ce_i && |(pending & irq_enable)) |=> receiver_fault_summary_o ##1
      (receiver_fault_summary_o || !$past(ce_i) || $past(~|(pending & irq_enable)));
  endproperty
  a_irq_follow: assert property (p_irq_follow)
    else $error("summary request missing");

endmodule

// File: verilog/sef_event_tracker.sv
// pending-event latches: set by an event, cleared by a read, set wins
`timescale 1ns/10ps
module sef_event_tracker #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] event_i,
  input  wire logic             clear_i,
  output logic      [WIDTH-1:0] pending_o
);

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pending_o <= '0;
    end else if (ce_i) begin
      // an event in the clearing cycle survives the clear
      pending_o <= event_i | (pending_o & {WIDTH{~clear_i}});
    end
  end

endmodule

// File: verilog/sef_pkg.sv
// types shared by the receiver error flag block
package sef_pkg;
  typedef logic [7:0]  sef_byte_t;
  typedef logic [15:0] sef_word_t;
  typedef enum {
    SEF_SEL_NONE,
    SEF_SEL_PRE_A_HI,
    SEF_SEL_PRE_A_LO,
    SEF_SEL_PRE_B_HI,
    SEF_SEL_PRE_B_LO,
    SEF_SEL_ERR,
    SEF_SEL_MASK
  } sef_sel_t;
endpackage

// File: verilog/sef_regs.svh
// register offsets, bit positions and reset values of the receiver error block
`ifndef SEF_REGS_SVH
`define SEF_REGS_SVH

`define SEF_ADDR_W        7
`define SEF_OFF_PRE_A_HI  7'h14
`define SEF_OFF_PRE_A_LO  7'h15
`define SEF_OFF_PRE_B_HI  7'h16
`define SEF_OFF_PRE_B_LO  7'h17
`define SEF_OFF_ERR       7'h18
`define SEF_OFF_MASK      7'h19

`define SEF_BIT_VALID     7
`define SEF_BIT_EMPH      6
`define SEF_BIT_NONAUDIO  5
`define SEF_BIT_NA_PRE    4
`define SEF_BIT_CRC       3
`define SEF_BIT_ABSENT    2
`define SEF_BIT_BIPHASE   1
`define SEF_BIT_LOCK      0

`define SEF_MASK_RST      8'h00
`define SEF_BYTE_ZERO     8'h00
`define SEF_WORD_ZERO     16'h0000

`endif
